// File: rtl/io_port_pkg.sv
// constants shared by the port bank and its port cells
package io_port_pkg;
    localparam int PORT_WIDTH = 8;
    localparam int DIGITAL_PORTS = 8;
    localparam int SEL_WIDTH = 4;
    // port select codes; digital ports map onto cell slots 0..7
    localparam logic [3:0] SEL_ADDRESS_DATA_PORT = 4'h0;
    localparam logic [3:0] SEL_HIGH_ADDRESS_PORT = 4'h2;
    localparam logic [3:0] SEL_ANALOG_INPUT_PORT_A = 4'h7;
    localparam logic [3:0] SEL_ANALOG_INPUT_PORT_B = 4'h8;
    localparam logic [3:0] SEL_PORT_NINE = 4'h9;
    localparam logic [2:0] SLOT_PORT_NINE = 3'h7;
    localparam logic [7:0] LATCH_RESET = 8'hFF;
    localparam logic [7:0] DIRECTION_RESET = 8'hFF;
    localparam logic [7:0] READ_ZERO = 8'h00;
    // direction window closes at this state_two_phase_two strobe
    localparam logic [1:0] WINDOW_STROBES = 2'h2;
endpackage : io_port_pkg

// File: rtl/io_port_cell.sv
// one 8-bit digital port: latch, direction register and pin drivers
module io_port_cell
    import io_port_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic latch_wr,
    input wire logic dir_wr,
    input wire logic [7:0] wdata,
    input wire logic bidir_mode,
    input wire logic ovr_en,
    input wire logic [7:0] ovr_oe,
    input wire logic [7:0] ovr_val,
    output logic [7:0] latch_q,
    output logic [7:0] dir_q,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe
);
    typedef struct packed {
        logic [7:0] latch;
        logic [7:0] dir;
        logic [7:0] pout;
        logic [7:0] poe;
    } cell_state_type;

    cell_state_type s_reg;
    cell_state_type s_next;

    always_comb begin
        s_next = s_reg;
        if (latch_wr) begin
            s_next.latch = wdata;
        end
        if (dir_wr) begin
            s_next.dir = wdata;
        end
        if (ovr_en) begin
            s_next.pout = ovr_val;
            s_next.poe = ovr_oe;
        end else if (bidir_mode) begin
            // dir bit one: driver off, pin is input
            s_next.pout = s_reg.latch;
            s_next.poe = ~s_reg.dir;
        end else begin
            // quasi: strong low only, high held by weak pull-up; dir ignored
            s_next.pout = s_reg.latch;
            s_next.poe = ~s_reg.latch;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_reg <= '{latch: LATCH_RESET, dir: DIRECTION_RESET, pout: LATCH_RESET,
                poe: 8'h00};
        end else begin
            s_reg <= s_next;
        end
    end

    assign latch_q = s_reg.latch;
    assign dir_q = s_reg.dir;
    assign pin_out = s_reg.pout;
    assign pin_oe = s_reg.poe;

    quasi_dir_ignored_a: assert property (@(posedge clk) disable iff (rst)
        (!bidir_mode && !ovr_en) |=> (pin_oe == ~$past(latch_q)))
        else $error("quasi mode driver not following latch");
    bidir_dir_drive_a: assert property (@(posedge clk) disable iff (rst)
        (bidir_mode && !ovr_en) |=> (pin_oe == ~$past(dir_q)) && (pin_out == $past(latch_q)))
        else $error("bidir driver not following direction");
endmodule : io_port_cell

// File: rtl/dual_mode_io_port_bank.sv
// port bank: eight digital ports, two analog input ports, external bus reuse
// Behaviour
// - 64 lines as eight 8-bit ports with latch, driver, input buffer.
// - structure select bit: clear is quasi-bidirectional, set is CMOS bidirectional.
// - structure select bit is clear after reset.
// - external access: address data port drives low address, then write data; floats on reads.
// - high address port drives upper address for 16-bit addresses, else latch.
// - input-only ports return pin levels; writes to them do nothing.
// - input-only ports sampled as one whole byte at one moment.
// - each digital port has a direction register; input-only ports have none.
// - set direction access bit, then next access goes to direction register.
// - direction access bit clears at second state_two_phase_two after set.
// - interrupts blocked while the direction access window is open.
// - direction registers reset to all ones.
// - in quasi mode direction registers do not affect drivers.
// - bidirectional mode: each pin set as input or output by direction.
// - shared address target decoded from current direction access bit.
module dual_mode_io_port_bank
    import io_port_pkg::*;
(
    // clock and reset
    input wire logic REF_CLK_IN,
    input wire logic RST_IN,
    // register access from the core
    input wire logic [io_port_pkg::SEL_WIDTH-1:0] PORT_SEL_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    input wire logic [io_port_pkg::PORT_WIDTH-1:0] WDATA_IN,
    output logic [io_port_pkg::PORT_WIDTH-1:0] RDATA_OUT,
    // control bits
    input wire logic STRUCT_SEL_WR_IN,
    input wire logic STRUCT_SEL_DATA_IN,
    input wire logic DIR_ACCESS_SET_IN,
    input wire logic STATE_TWO_PHASE_TWO_IN,
    output logic STRUCT_SEL_OUT,
    output logic DIR_ACCESS_OUT,
    output logic INT_BLOCK_OUT,
    // external memory access
    input wire logic EXT_ACCESS_IN,
    input wire logic EXT_ADDR_PHASE_IN,
    input wire logic EXT_WRITE_IN,
    input wire logic EXT_WIDE_IN,
    input wire logic [15:0] EXT_ADDR_IN,
    input wire logic [io_port_pkg::PORT_WIDTH-1:0] EXT_WDATA_IN,
    output logic [io_port_pkg::PORT_WIDTH-1:0] EXT_RDATA_OUT,
    // pins
    input wire logic [63:0] PIN_IN,
    output logic [63:0] PIN_OUT,
    output logic [63:0] PIN_OE_OUT,
    input wire logic [io_port_pkg::PORT_WIDTH-1:0] ANALOG_A_IN,
    input wire logic [io_port_pkg::PORT_WIDTH-1:0] ANALOG_B_IN
);
    import io_port_pkg::*;

    typedef struct packed {
        logic struct_sel;
        logic dir_access;
        logic [1:0] strobes;
        logic [7:0] rdata;
        logic [7:0] ext_rdata;
    } bank_state_type;

    bank_state_type s_reg;
    bank_state_type s_next;

    logic [7:0] latch_q [DIGITAL_PORTS];
    logic [7:0] dir_q [DIGITAL_PORTS];
    logic [7:0] pin_byte [DIGITAL_PORTS];
    logic digital_sel;
    logic [2:0] slot;

    // ****************************************************************
    // address decode
    // ****************************************************************
    always_comb begin
        digital_sel = 1'b0;
        slot = 3'h0;
        if (PORT_SEL_IN == SEL_PORT_NINE) begin
            digital_sel = 1'b1;
            slot = SLOT_PORT_NINE;
        end else if (PORT_SEL_IN < SEL_ANALOG_INPUT_PORT_A) begin
            digital_sel = 1'b1;
            slot = PORT_SEL_IN[2:0];
        end
    end

    // ****************************************************************
    // port cells
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < DIGITAL_PORTS; g++) begin : g_port
            logic hit;
            logic ovr_en;
            logic [7:0] ovr_oe;
            logic [7:0] ovr_val;
            assign hit = digital_sel && (slot == 3'(g)) && WR_IN;
            assign pin_byte[g] = PIN_IN[g*8 +: 8];
            if (g == 0) begin : g_ad
                assign ovr_en = EXT_ACCESS_IN;
                assign ovr_oe = (EXT_ADDR_PHASE_IN || EXT_WRITE_IN) ? 8'hFF : 8'h00;
                assign ovr_val = EXT_ADDR_PHASE_IN ? EXT_ADDR_IN[7:0] : EXT_WDATA_IN;
            end else if (g == 2) begin : g_ha
                assign ovr_en = EXT_ACCESS_IN && EXT_WIDE_IN;
                assign ovr_oe = 8'hFF;
                assign ovr_val = EXT_ADDR_IN[15:8];
            end else begin : g_plain
                assign ovr_en = 1'b0;
                assign ovr_oe = 8'h00;
                assign ovr_val = 8'h00;
            end
            io_port_cell u_cell (
                .clk(REF_CLK_IN),
                .rst(RST_IN),
                .latch_wr(hit && !s_reg.dir_access),
                .dir_wr(hit && s_reg.dir_access),
                .wdata(WDATA_IN),
                .bidir_mode(s_reg.struct_sel),
                .ovr_en(ovr_en),
                .ovr_oe(ovr_oe),
                .ovr_val(ovr_val),
                .latch_q(latch_q[g]),
                .dir_q(dir_q[g]),
                .pin_out(PIN_OUT[g*8 +: 8]),
                .pin_oe(PIN_OE_OUT[g*8 +: 8])
            );
        end
    endgenerate

    // ****************************************************************
    // control bits, window timing and read path
    // ****************************************************************
    always_comb begin
        s_next = s_reg;
        if (STRUCT_SEL_WR_IN) begin
            s_next.struct_sel = STRUCT_SEL_DATA_IN;
        end
        if (s_reg.dir_access && STATE_TWO_PHASE_TWO_IN) begin
            s_next.strobes = s_reg.strobes + 2'h1;
            if (s_reg.strobes + 2'h1 == WINDOW_STROBES) begin
                s_next.dir_access = 1'b0;
                s_next.strobes = 2'h0;
            end
        end
        if (DIR_ACCESS_SET_IN) begin
            s_next.dir_access = 1'b1;
            s_next.strobes = 2'h0;
        end
        if (RD_IN) begin
            if (digital_sel) begin
                s_next.rdata = s_reg.dir_access ? dir_q[slot] : pin_byte[slot];
            end else if (PORT_SEL_IN == SEL_ANALOG_INPUT_PORT_A) begin
                s_next.rdata = ANALOG_A_IN;
            end else if (PORT_SEL_IN == SEL_ANALOG_INPUT_PORT_B) begin
                s_next.rdata = ANALOG_B_IN;
            end else begin
                s_next.rdata = READ_ZERO;
            end
        end
        if (EXT_ACCESS_IN && !EXT_ADDR_PHASE_IN && !EXT_WRITE_IN) begin
            s_next.ext_rdata = pin_byte[0];
        end
    end

    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            s_reg <= '{struct_sel: 1'b0, dir_access: 1'b0, strobes: 2'h0,
                rdata: 8'h00, ext_rdata: 8'h00};
        end else begin
            s_reg <= s_next;
        end
    end

    assign RDATA_OUT = s_reg.rdata;
    assign EXT_RDATA_OUT = s_reg.ext_rdata;
    assign STRUCT_SEL_OUT = s_reg.struct_sel;
    assign DIR_ACCESS_OUT = s_reg.dir_access;
    assign INT_BLOCK_OUT = s_reg.dir_access;

    // ****************************************************************
    // checks
    // ****************************************************************
    // helper: timing strobes seen while the window is open
    logic [1:0] window_seen_reg;

    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            window_seen_reg <= 2'h0;
        end else if (DIR_ACCESS_SET_IN) begin
            window_seen_reg <= 2'h0;
        end else if (DIR_ACCESS_OUT && STATE_TWO_PHASE_TWO_IN) begin
            window_seen_reg <= window_seen_reg + 2'h1;
        end
    end

    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (RST_IN);

    struct_sel_write_a: assert property (
        STRUCT_SEL_WR_IN |=> STRUCT_SEL_OUT == $past(STRUCT_SEL_DATA_IN))
        else $error("structure select not written");
    window_close_a: assert property (
        (DIR_ACCESS_OUT && STATE_TWO_PHASE_TWO_IN && !DIR_ACCESS_SET_IN
        && window_seen_reg == WINDOW_STROBES - 2'h1) |=> !DIR_ACCESS_OUT)
        else $error("direction window did not close");
    window_hold_a: assert property (
        (DIR_ACCESS_OUT && !DIR_ACCESS_SET_IN
        && (!STATE_TWO_PHASE_TWO_IN || window_seen_reg != WINDOW_STROBES - 2'h1))
        |=> DIR_ACCESS_OUT)
        else $error("direction window closed early");
    window_open_a: assert property (
        DIR_ACCESS_SET_IN |=> DIR_ACCESS_OUT && INT_BLOCK_OUT)
        else $error("direction window did not open");
    irq_block_a: assert property (
        INT_BLOCK_OUT == DIR_ACCESS_OUT)
        else $error("interrupt block not tied to window");
    analog_read_a: assert property (
        (RD_IN && PORT_SEL_IN == SEL_ANALOG_INPUT_PORT_A) |=> RDATA_OUT == $past(ANALOG_A_IN))
        else $error("input-only port not sampled as byte");
    dir_read_a: assert property (
        (RD_IN && digital_sel && DIR_ACCESS_OUT) |=> RDATA_OUT == $past(dir_q[slot]))
        else $error("direction register not read in window");
    ext_addr_low_a: assert property (
        (EXT_ACCESS_IN && EXT_ADDR_PHASE_IN) |=> PIN_OUT[7:0] == $past(EXT_ADDR_IN[7:0])
        && PIN_OE_OUT[7:0] == 8'hFF)
        else $error("low address not driven");
    ext_addr_high_a: assert property (
        (EXT_ACCESS_IN && EXT_WIDE_IN) |=> PIN_OUT[23:16] == $past(EXT_ADDR_IN[15:8]))
        else $error("high address not driven");
    ext_read_float_a: assert property (
        (EXT_ACCESS_IN && !EXT_ADDR_PHASE_IN && !EXT_WRITE_IN) |=> PIN_OE_OUT[7:0] == 8'h00)
        else $error("data read phase still driving");

    bidir_mode_c: cover property (STRUCT_SEL_WR_IN && STRUCT_SEL_DATA_IN);
    dir_write_c: cover property (DIR_ACCESS_OUT && WR_IN && digital_sel);
    ext_read_c: cover property (EXT_ACCESS_IN && !EXT_ADDR_PHASE_IN && !EXT_WRITE_IN);
    window_end_c: cover property (DIR_ACCESS_OUT ##1 !DIR_ACCESS_OUT);
endmodule : dual_mode_io_port_bank

// File: test/pin_load_model.sv
// pin loads: pull-ups on every digital line plus an optional external driver
module pin_load_model (
    // from the port bank
    input wire logic [63:0] pin_out_in,
    input wire logic [63:0] pin_oe_in,
    // far-side drivers, e.g. external memory data on reads
    input wire logic [63:0] ext_en_in,
    input wire logic [63:0] ext_val_in,
    // resolved line levels
    output logic [63:0] level_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // bank driver first, then the far side, else the pull-up
    always_comb begin
        for (int i = 0; i < 64; i++) begin
            level_out[i] = pin_oe_in[i] ? pin_out_in[i]
                : (ext_en_in[i] ? ext_val_in[i] : 1'b1);
        end
    end
endmodule : pin_load_model

// File: test/testbench.sv
// self-checking bench for the dual mode port bank
module testbench;
    import io_port_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {logic [3:0] sel; logic [2:0] slot; logic [7:0] val;} row_type;
    logic clk, rst, wr, rd, ss_wr, ss_d, da_set, strobe, acc, ap, ewr, wide, da, ib, ss;
    logic [3:0] sel;
    logic [7:0] wdata, rdata, ewd, erd, an_a, an_b;
    logic [15:0] addr;
    logic [63:0] pins, pout, poe, xen, xval;
    int err_count = 0;
    int n_tests = 0;
    row_type rows [8] = '{'{4'h0, 3'h0, 8'h5A}, '{4'h1, 3'h1, 8'h00}, '{4'h2, 3'h2, 8'hC3},
        '{4'h3, 3'h3, 8'h55}, '{4'h4, 3'h4, 8'hFF}, '{4'h5, 3'h5, 8'h81},
        '{4'h6, 3'h6, 8'h7E}, '{4'h9, 3'h7, 8'h3C}};
    dual_mode_io_port_bank uut (.REF_CLK_IN(clk), .RST_IN(rst), .PORT_SEL_IN(sel), .WR_IN(wr),
        .RD_IN(rd), .WDATA_IN(wdata), .RDATA_OUT(rdata), .STRUCT_SEL_WR_IN(ss_wr),
        .STRUCT_SEL_DATA_IN(ss_d), .DIR_ACCESS_SET_IN(da_set), .STATE_TWO_PHASE_TWO_IN(strobe),
        .STRUCT_SEL_OUT(ss), .DIR_ACCESS_OUT(da), .INT_BLOCK_OUT(ib), .EXT_ACCESS_IN(acc),
        .EXT_ADDR_PHASE_IN(ap), .EXT_WRITE_IN(ewr), .EXT_WIDE_IN(wide), .EXT_ADDR_IN(addr),
        .EXT_WDATA_IN(ewd), .EXT_RDATA_OUT(erd), .PIN_IN(pins), .PIN_OUT(pout),
        .PIN_OE_OUT(poe), .ANALOG_A_IN(an_a), .ANALOG_B_IN(an_b));
    pin_load_model loads (.pin_out_in(pout), .pin_oe_in(poe), .ext_en_in(xen),
        .ext_val_in(xval), .level_out(pins));
    // ********************************
    // tasks
    // ********************************
    task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic wr_port(input logic [3:0] s, input logic [7:0] d);
        sel = s;
        wdata = d;
        wr = 1'b1;
        cyc(1);
        wr = 1'b0;
    endtask : wr_port
    task automatic rd_port(input logic [3:0] s);
        sel = s;
        rd = 1'b1;
        cyc(1);
        rd = 1'b0;
    endtask : rd_port
    task automatic pulse_strobe();
        strobe = 1'b1;
        cyc(1);
        strobe = 1'b0;
    endtask : pulse_strobe
    task automatic close_out();
        $display("tests %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out
    // ********************************
    // clock, watchdog, sequence
    // ********************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #100000;
        err_count++;
        close_out();
    end
    initial begin
        {rst, wr, rd, ss_wr, ss_d, da_set, strobe, acc, ap, ewr, wide} = 11'h400;
        {sel, wdata, ewd, an_a, an_b, addr} = '0;
        {xen, xval} = '0;
        cyc(4);
        check("struct_sel", 1'b0, ss);
        check("pin_oe", 64'h0, poe);
        rst = 1'b0;
        foreach (rows[i]) begin
            wr_port(rows[i].sel, rows[i].val);
            cyc(2);
            check("quasi_oe", rows[i].val ^ 8'hFF, poe[rows[i].slot*8 +: 8]);
            check("quasi_out", rows[i].val, pout[rows[i].slot*8 +: 8]);
            rd_port(rows[i].sel);
            check("port_read", rows[i].val, rdata);
        end
        an_a = 8'h3C;
        an_b = 8'hC3;
        wr_port(4'h7, 8'h00);
        wr_port(4'h8, 8'h00);
        rd_port(4'h7);
        check("analog_a", 8'h3C, rdata);
        check("analog_wr_ignored", 8'h5A, pout[7:0]);
        rd_port(4'h8);
        check("analog_b_masked", 8'h03, rdata & 8'h0F);
        da_set = 1'b1;
        cyc(1);
        da_set = 1'b0;
        check("dir_access", 1'b1, da);
        check("int_block", 1'b1, ib);
        wr_port(4'h3, 8'h0F);
        rd_port(4'h3);
        check("dir_read", 8'h0F, rdata);
        check("quasi_ignores_dir", 8'hAA, poe[31:24]);
        pulse_strobe();
        check("window_open", 1'b1, da);
        pulse_strobe();
        cyc(1);
        check("window_closed", 1'b0, da);
        check("int_unblock", 1'b0, ib);
        rd_port(4'h3);
        check("port_after_window", 8'h55, rdata);
        rd_port(4'hA);
        check("unmapped_read", 8'h00, rdata);
        ss_d = 1'b1;
        ss_wr = 1'b1;
        cyc(1);
        ss_wr = 1'b0;
        cyc(1);
        check("struct_sel_set", 1'b1, ss);
        check("bidir_oe", 8'hF0, poe[31:24]);
        check("dir_reset_ff", 8'h00, poe[7:0]);
        rd_port(4'h3);
        check("bidir_pins", 8'h5F, rdata);
        {acc, ap, wide, addr} = {3'b111, 16'hA55A};
        cyc(2);
        check("addr_low", {8'hFF, 8'h5A}, {poe[7:0], pout[7:0]});
        check("addr_high", {8'hFF, 8'hA5}, {poe[23:16], pout[23:16]});
        wide = 1'b0;
        {ap, ewr, ewd} = {2'b01, 8'h96};
        cyc(2);
        check("narrow_latch", 8'hC3, pout[23:16]);
        check("data_write", {8'hFF, 8'h96}, {poe[7:0], pout[7:0]});
        ewr = 1'b0;
        {xen[7:0], xval[7:0]} = {8'hFF, 8'h69};
        cyc(3);
        check("data_read", 8'h69, erd);
        {acc, xen} = '0;
        rst = 1'b1;
        cyc(1);
        check("reset_again", 1'b0, ss);
        rst = 1'b0;
        cyc(2);
        close_out();
    end
endmodule : testbench
